// [include/e1nb_pkg.sv]
// constants for the timeslot-zero spare-bit framer
package e1nb_pkg;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LINK_PULSE_NS = 244;
  localparam int LINK_PULSE_CYC = (LINK_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int LINK_SAMPLE_DLY = 2;
  localparam int PULSE_W = 8;
  // ==========================================
  // frame structure
  localparam logic [3:0] MF_LAST = 4'h0;
  localparam logic [7:0] TS0_SA_FIRST = 8'h03;
  localparam logic [7:0] TS0_SA_LAST = 8'h07;
  localparam logic [7:0] TS0_ALARM = 8'h02;
  localparam logic [7:0] TS0_FIXED_ONE = 8'h01;
  localparam logic [6:0] FAS_WORD = 7'h1B;
  localparam logic [5:0] MFAS_WORD = 6'h0B;
  localparam logic [3:0] FRAME_LAST_MFAS = 4'hB;
  localparam logic [3:0] FRAME_E1 = 4'hD;
  localparam int SA_COUNT = 5;
  // ==========================================
  // pages and offsets
  localparam logic [7:0] PAGE_MASTER_CTRL = 8'h01;
  localparam logic [7:0] PAGE_MASTER_STAT = 8'h03;
  localparam logic [7:0] PAGE_TX_NBB = 8'h0D;
  localparam logic [7:0] PAGE_RX_NBB = 8'h0E;
  localparam logic [7:0] OFF_DL_SELECT = 8'h10;
  localparam logic [7:0] OFF_MF_STATUS = 8'h12;
  localparam logic [7:0] OFF_TRANSP_SEL = 8'h17;
  localparam logic [7:0] OFF_SA_IRQ_CTRL = 8'h19;
  localparam logic [7:0] OFF_MF_IRQ_MASK = 8'h1D;
  localparam logic [7:0] OFF_NBB_SA4 = 8'h00;
  // ==========================================
  // fields
  localparam int ST_MF_ALIGN = 0;
  localparam int ST_SA_CHG_LSB = 1;
  localparam int MASK_MF = 0;
  localparam int MASK_SA = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] NBB_RST = 8'hFF;
endpackage

// [rtl/e1nb_top.sv]
// spare-bit buffers, data link and timeslot-zero words of an E1 framer
// Operation
// - even frames carry the alignment word, odd frames the non-alignment word
// - bit 1 is the MSB and goes first; bit 8 is the LSB
// - alignment word C,0011011; other word 1 in bit 2, alarm, Sa4..Sa8
// - bit 1 of frames 1-11 is 001011; frames 13,15 carry E1,E2
// - five buffer bytes, Sa4..Sa8; columns F1 (MSB) to F15 (LSB)
// - transmit buffer on page 0DH, receive buffer on page 0EH
// - a link-selected spare bit overrides the transmit buffer value
// - multiframe start sets the align flag and a maskable interrupt
// - change interrupts per bit Sa5..Sa8 and per nibble Sa5..Sa8
// - per-bit transparent channel-zero spare bits from backplane data
// - each selected spare bit gives 4 kb/s, once per 250 us
// - select word bits 4-0 at 10H put Sa4..Sa8 on the link
// - tx link clock pulses 244 ns (here 48 cycles, 240 ns) in selected cells; data taken at rise
// - link-selected positions ignore every other source
// - rx link data is line data; rx clock pulses in selected cells
// - receive slips neither drop nor repeat link bits
// - page written with select bit low; registers with it high
// - receive buffer page read-only, transmit page read/write
`timescale 1ns/1ps

// ==========================================
// fifo
module e1nb_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign o_in_ready = count != FULL;
  assign o_out_valid = count != '0;
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// ==========================================
// top
module e1nb_top #(
  parameter int LINK_FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // processor port
  input wire logic i_cpu_cs,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [4:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  // transmit backplane timing and line
  input wire logic i_tx_bit_clock,
  input wire logic i_tx_frame_pulse,
  input wire logic i_backplane_data_in,
  input wire logic i_tx_crc_bit,
  input wire logic i_tx_remote_alarm,
  input wire logic [1:0] i_tx_remote_crc_err,
  output logic o_tx_line_data,
  // receive extracted timing and line
  input wire logic i_rx_line_clock,
  input wire logic i_rx_frame_pulse,
  input wire logic i_rx_multiframe_pulse,
  input wire logic i_rx_line_data,
  // data link pins
  output logic o_tx_link_clock,
  input wire logic i_tx_link_data,
  output logic o_rx_link_clock,
  output logic o_rx_link_data,
  // interrupts
  output logic o_multiframe_align_irq,
  output logic o_spare_change_irq
);
  import e1nb_pkg::*;

  function automatic logic is_sa(input logic [7:0] idx);
    return idx >= TS0_SA_FIRST && idx <= TS0_SA_LAST;
  endfunction

  // select word bit 4 is Sa4 (ts0 index 3), bit 0 is Sa8 (index 7)
  function automatic logic sa_on(input logic [4:0] word, input logic [7:0] idx);
    return is_sa(idx) && word[3'(TS0_SA_LAST - idx)];
  endfunction

  function automatic logic [2:0] sa_num(input logic [7:0] idx);
    return 3'(idx - TS0_SA_FIRST);
  endfunction

  // F1 in the MSB through F15 in the LSB
  function automatic logic [2:0] col(input logic [3:0] frame);
    return 3'(3'h7 - frame[3:1]);
  endfunction

  // ==========================================
  // synchronisers
  localparam int NS = 8;
  logic [NS-1:0] meta;
  logic [NS-1:0] sync;
  logic tx_clk_q;
  logic rx_clk_q;
  logic tx_bit_edge;
  logic rx_bit_edge;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      sync <= '0;
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      meta <= {i_tx_bit_clock, i_tx_frame_pulse, i_backplane_data_in, i_rx_line_clock,
               i_rx_frame_pulse, i_rx_multiframe_pulse, i_rx_line_data, i_tx_link_data};
      sync <= meta;
      tx_clk_q <= sync[7];
      rx_clk_q <= sync[4];
    end
  end

  assign tx_bit_edge = sync[7] && !tx_clk_q;
  assign rx_bit_edge = sync[4] && !rx_clk_q;

  // ==========================================
  // registers
  logic [7:0] page;
  logic [4:0] dl_select;
  logic [4:0] transp_sel;
  logic [7:0] sa_irq_ctrl;
  logic [1:0] mf_irq_mask;
  logic [7:0] tx_nbb [SA_COUNT];
  logic [7:0] rx_nbb [SA_COUNT];
  logic [4:0] status;
  logic [7:0] rd_val;
  logic wr_reg;
  logic rd_status;
  logic [7:0] reg_off;

  assign reg_off = {4'h1, i_cpu_addr[3:0]};
  assign wr_reg = i_cpu_cs && i_cpu_wr && i_cpu_addr[4];
  assign rd_status = i_cpu_cs && i_cpu_rd && i_cpu_addr[4] && page == PAGE_MASTER_STAT
                     && reg_off == OFF_MF_STATUS;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      page <= RST_BYTE;
      dl_select <= '0;
      transp_sel <= '0;
      sa_irq_ctrl <= RST_BYTE;
      mf_irq_mask <= '1;
      for (int i = 0; i < SA_COUNT; i++) begin
        tx_nbb[i] <= NBB_RST;
      end
    end else if (i_cpu_cs && i_cpu_wr && !i_cpu_addr[4]) begin
      page <= i_cpu_wdata;
    end else if (wr_reg && page == PAGE_MASTER_CTRL) begin
      case (reg_off)
        OFF_DL_SELECT: dl_select <= i_cpu_wdata[4:0];
        OFF_TRANSP_SEL: transp_sel <= i_cpu_wdata[4:0];
        OFF_SA_IRQ_CTRL: sa_irq_ctrl <= i_cpu_wdata;
        OFF_MF_IRQ_MASK: mf_irq_mask <= i_cpu_wdata[1:0];
        default: ;
      endcase
    end else if (wr_reg && page == PAGE_TX_NBB && i_cpu_addr[3:0] < 4'(SA_COUNT)) begin
      tx_nbb[3'(i_cpu_addr[3:0])] <= i_cpu_wdata;
    end
  end

  // receive buffer page has no write path
  always_comb begin
    rd_val = RST_BYTE;
    if (!i_cpu_addr[4]) begin
      rd_val = page;
    end else if (page == PAGE_MASTER_CTRL) begin
      case (reg_off)
        OFF_DL_SELECT: rd_val = {3'h0, dl_select};
        OFF_TRANSP_SEL: rd_val = {3'h0, transp_sel};
        OFF_SA_IRQ_CTRL: rd_val = sa_irq_ctrl;
        OFF_MF_IRQ_MASK: rd_val = {6'h00, mf_irq_mask};
        default: rd_val = RST_BYTE;
      endcase
    end else if (page == PAGE_MASTER_STAT && reg_off == OFF_MF_STATUS) begin
      rd_val = {3'h0, status};
    end else if (i_cpu_addr[3:0] < 4'(SA_COUNT)) begin
      if (page == PAGE_TX_NBB) begin
        rd_val = tx_nbb[3'(i_cpu_addr[3:0])];
      end else if (page == PAGE_RX_NBB) begin
        rd_val = rx_nbb[3'(i_cpu_addr[3:0])];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cpu_rdata <= RST_BYTE;
    end else if (i_cpu_cs && i_cpu_rd) begin
      o_cpu_rdata <= rd_val;
    end
  end

  // ==========================================
  // transmit timing and word build
  logic [7:0] tx_idx;
  logic [3:0] tx_frame;
  logic [7:0] next_tx_idx;
  logic [3:0] next_tx_frame;
  logic [7:0] tx_shadow [SA_COUNT];
  logic next_tx_bit;
  logic tx_link_cell;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_pop;
  logic fifo_push;

  assign next_tx_idx = sync[6] ? '0 : tx_idx + 8'h01;
  assign next_tx_frame = sync[6] ? tx_frame + 4'h1 : tx_frame;
  assign tx_link_cell = next_tx_frame[0] && sa_on(dl_select, next_tx_idx);
  assign fifo_pop = tx_bit_edge && tx_link_cell;

  always_comb begin
    next_tx_bit = sync[5];
    if (next_tx_idx <= TS0_SA_LAST) begin
      if (!next_tx_frame[0]) begin
        if (next_tx_idx == '0) begin
          next_tx_bit = i_tx_crc_bit;
        end else begin
          next_tx_bit = FAS_WORD[3'(TS0_SA_LAST - next_tx_idx)];
        end
      end else if (next_tx_idx == '0) begin
        if (next_tx_frame <= FRAME_LAST_MFAS) begin
          next_tx_bit = MFAS_WORD[3'(3'h5 - next_tx_frame[3:1])];
        end else begin
          next_tx_bit = i_tx_remote_crc_err[next_tx_frame == FRAME_E1];
        end
      end else if (next_tx_idx == TS0_FIXED_ONE) begin
        next_tx_bit = 1'b1;
      end else if (next_tx_idx == TS0_ALARM) begin
        next_tx_bit = i_tx_remote_alarm;
      end else if (tx_link_cell) begin
        next_tx_bit = fifo_out_valid ? fifo_out_data : 1'b1;
      end else if (sa_on(transp_sel, next_tx_idx)) begin
        next_tx_bit = sync[5];
      end else begin
        next_tx_bit = tx_shadow[sa_num(next_tx_idx)][col(next_tx_frame)];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_idx <= '0;
      tx_frame <= '0;
      o_tx_line_data <= 1'b1;
      for (int i = 0; i < SA_COUNT; i++) begin
        tx_shadow[i] <= NBB_RST;
      end
    end else if (tx_bit_edge) begin
      tx_idx <= next_tx_idx;
      tx_frame <= next_tx_frame;
      o_tx_line_data <= next_tx_bit;
      if (sync[6] && next_tx_frame == MF_LAST) begin
        tx_shadow <= tx_nbb;
      end
    end
  end

  // ==========================================
  // transmit link clock and sampling
  logic [PULSE_W-1:0] tx_pulse_cnt;

  // a full fifo holds the clock back so no link bit is lost
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_pulse_cnt <= '0;
    end else if (tx_bit_edge && tx_link_cell && fifo_in_ready) begin
      tx_pulse_cnt <= PULSE_W'(LINK_PULSE_CYC);
    end else if (tx_pulse_cnt != '0) begin
      tx_pulse_cnt <= tx_pulse_cnt - 1'b1;
    end
  end

  assign o_tx_link_clock = tx_pulse_cnt != '0;
  // the pin value at the rising edge reaches sync after the synchroniser delay
  assign fifo_push = tx_pulse_cnt == PULSE_W'(LINK_PULSE_CYC - LINK_SAMPLE_DLY);

  e1nb_fifo #(
    .WIDTH(1),
    .DEPTH(LINK_FIFO_DEPTH)
  ) u_link_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(sync[0]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // ==========================================
  // receive timing, link output and capture
  logic [7:0] rx_idx;
  logic [3:0] rx_frame;
  logic [7:0] next_rx_idx;
  logic [3:0] next_rx_frame;
  logic [7:0] rx_acc [SA_COUNT];
  logic [4:0] rx_prev;
  logic [PULSE_W-1:0] rx_pulse_cnt;
  logic rx_cell;
  logic mf_start;
  logic [3:0] chg_set;

  assign next_rx_idx = sync[3] ? '0 : rx_idx + 8'h01;
  assign next_rx_frame = !sync[3] ? rx_frame : (sync[2] ? MF_LAST : rx_frame + 4'h1);
  assign rx_cell = rx_bit_edge && next_rx_frame[0] && is_sa(next_rx_idx);
  assign mf_start = rx_bit_edge && sync[3] && sync[2];

  // taken ahead of the elastic buffer, so slips never touch link bits
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_idx <= '0;
      rx_frame <= '0;
      o_rx_link_data <= 1'b1;
    end else if (rx_bit_edge) begin
      rx_idx <= next_rx_idx;
      rx_frame <= next_rx_frame;
      o_rx_link_data <= sync[1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_pulse_cnt <= '0;
    end else if (rx_cell && sa_on(dl_select, next_rx_idx)) begin
      rx_pulse_cnt <= PULSE_W'(LINK_PULSE_CYC);
    end else if (rx_pulse_cnt != '0) begin
      rx_pulse_cnt <= rx_pulse_cnt - 1'b1;
    end
  end

  assign o_rx_link_clock = rx_pulse_cnt != '0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_prev <= '1;
      for (int i = 0; i < SA_COUNT; i++) begin
        rx_acc[i] <= NBB_RST;
        rx_nbb[i] <= NBB_RST;
      end
    end else begin
      if (rx_cell) begin
        rx_acc[sa_num(next_rx_idx)][col(next_rx_frame)] <= sync[1];
        rx_prev[sa_num(next_rx_idx)] <= sync[1];
      end
      if (mf_start) begin
        rx_nbb <= rx_acc;
      end
    end
  end

  // ctrl bit i / i+4: bit / nibble change of Sa(8-i)
  always_comb begin
    chg_set = '0;
    for (int i = 0; i < 4; i++) begin
      if (rx_cell && sa_num(next_rx_idx) == 3'(4 - i) && sa_irq_ctrl[i]
          && sync[1] != rx_prev[4 - i]) begin
        chg_set[i] = 1'b1;
      end
      if (mf_start && sa_irq_ctrl[i + 4] && (rx_acc[4 - i][7:4] != rx_nbb[4 - i][7:4]
          || rx_acc[4 - i][3:0] != rx_nbb[4 - i][3:0])) begin
        chg_set[i] = 1'b1;
      end
    end
  end

  // ==========================================
  // status flags: clear on read, a coincident set wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status <= '0;
    end else begin
      status[ST_MF_ALIGN] <= mf_start || (status[ST_MF_ALIGN] && !rd_status);
      status[ST_SA_CHG_LSB +: 4] <= chg_set | (status[ST_SA_CHG_LSB +: 4] & {4{!rd_status}});
    end
  end

  assign o_multiframe_align_irq = status[ST_MF_ALIGN] && !mf_irq_mask[MASK_MF];
  assign o_spare_change_irq = (status[ST_SA_CHG_LSB +: 4] != '0) && !mf_irq_mask[MASK_SA];
endmodule

// [sim/e1nb_sva.sv]
// port assertions for the spare-bit framer
`timescale 1ns/1ps
module e1nb_sva
  import e1nb_pkg::*;
(
  // watched ports
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cpu_cs,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [4:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic i_rx_line_clock,
  input wire logic i_rx_line_data,
  input wire logic o_tx_link_clock,
  input wire logic o_rx_link_clock,
  input wire logic o_rx_link_data,
  input wire logic o_multiframe_align_irq
);
  logic [7:0] page;
  logic [4:0] sel;
  logic mmask;
  int txw;
  int rxw;
  int idle;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // shadow of the control registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      page <= 8'h00;
      sel <= 5'h00;
      mmask <= 1'b1;
    end else if (i_cpu_cs && i_cpu_wr) begin
      if (!i_cpu_addr[4]) page <= i_cpu_wdata;
      else if (page == 8'h01 && i_cpu_addr[3:0] == 4'h0) sel <= i_cpu_wdata[4:0];
      else if (page == 8'h01 && i_cpu_addr[3:0] == 4'hD) mmask <= i_cpu_wdata[0];
    end
  end
  // ==========================================
  // pulse widths and idle time
  always_ff @(posedge i_clk) begin
    txw <= (i_sys_rst || !o_tx_link_clock) ? 0 : txw + 1;
    rxw <= (i_sys_rst || !o_rx_link_clock) ? 0 : rxw + 1;
    idle <= (i_sys_rst || sel != 5'h00) ? 0 : (idle < 64 ? idle + 1 : idle);
  end
  // ==========================================
  // assertions
  sequence s_rx_edge;
    $rose(i_rx_line_clock);
  endsequence
  sequence s_rd_unmapped;
    i_cpu_cs && i_cpu_rd && i_cpu_addr[4] && !(page inside {8'h01, 8'h03, 8'h0D, 8'h0E});
  endsequence
  AST_TX_PULSE_WIDTH: assert property ($fell(o_tx_link_clock) |-> txw == LINK_PULSE_CYC)
    else $error("tx link clock pulse width wrong");
  AST_RX_PULSE_WIDTH: assert property ($fell(o_rx_link_clock) |-> rxw == LINK_PULSE_CYC)
    else $error("rx link clock pulse width wrong");
  AST_TX_IDLE: assert property (idle == 64 |-> !o_tx_link_clock)
    else $error("tx link clock active with nothing selected");
  AST_RX_IDLE: assert property (idle == 64 |-> !o_rx_link_clock)
    else $error("rx link clock active with nothing selected");
  AST_RDATA_HOLD: assert property (!$past(i_cpu_cs && i_cpu_rd) |-> $stable(o_cpu_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (s_rd_unmapped |=> o_cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_MASKED: assert property (mmask && $past(mmask) && $past(mmask, 2) |-> !o_multiframe_align_irq)
    else $error("masked align interrupt raised");
  AST_RX_DATA_FOLLOW: assert property (s_rx_edge |-> ##6 o_rx_link_data == i_rx_line_data)
    else $error("rx link data does not follow line data");
endmodule

bind e1nb_top e1nb_sva chk_u (.i_clk, .i_sys_rst, .i_cpu_cs, .i_cpu_wr, .i_cpu_rd, .i_cpu_addr, .i_cpu_wdata,
  .o_cpu_rdata, .i_rx_line_clock, .i_rx_line_data, .o_tx_link_clock, .o_rx_link_clock, .o_rx_link_data,
  .o_multiframe_align_irq);

// [sim/e1nb_link_ctrl.sv]
// external data link controller feeding the tx link
`timescale 1ns/1ps
module e1nb_link_ctrl (
  // link pins
  input wire logic i_link_clock,
  output logic o_link_data
);
  logic [7:0] sr = 8'h5A;
  initial o_link_data = 1'b1;
  // next bit set up after each pulse so it is steady at the sampling rise
  always @(negedge i_link_clock) begin
    sr <= {sr[6:0], sr[7] ^ sr[5] ^ sr[4] ^ sr[3]};
    o_link_data <= sr[0];
  end
endmodule

// [sim/e1nb_top_test.sv]
// self-checking bench for the spare-bit framer
`timescale 1ns/1ps
module e1nb_top_test;
  import e1nb_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, i_cpu_cs = 0, i_cpu_wr = 0, i_cpu_rd = 0;
  logic [4:0] i_cpu_addr = 5'h00;
  logic [7:0] i_cpu_wdata = 8'h00;
  logic i_tx_bit_clock = 0, i_tx_frame_pulse = 0, i_backplane_data_in = 0, i_tx_crc_bit = 0;
  logic i_tx_remote_alarm = 0, i_rx_line_clock = 0, i_rx_frame_pulse = 0, i_rx_multiframe_pulse = 0;
  logic i_rx_line_data = 0, i_tx_link_data;
  logic [1:0] i_tx_remote_crc_err = 2'h0;
  logic [7:0] o_cpu_rdata;
  logic o_tx_line_data, o_tx_link_clock, o_rx_link_clock, o_rx_link_data, o_multiframe_align_irq;
  logic o_spare_change_irq;
  int n_errors = 0, tests_run = 0;
  logic [15:0] seed = 16'h000F;
  logic [4:0] sel = 5'h11, tsel = 5'h03;
  logic [7:0] txbuf [5], shadow [5], rxacc [5], rxexp [5];
  logic chg5 = 0, prev5 = 1;
  logic q [$];
  e1nb_top dut_u (.i_clk, .i_sys_rst, .i_cpu_cs, .i_cpu_wr, .i_cpu_rd, .i_cpu_addr, .i_cpu_wdata, .o_cpu_rdata,
    .i_tx_bit_clock, .i_tx_frame_pulse, .i_backplane_data_in, .i_tx_crc_bit, .i_tx_remote_alarm,
    .i_tx_remote_crc_err, .o_tx_line_data, .i_rx_line_clock, .i_rx_frame_pulse, .i_rx_multiframe_pulse,
    .i_rx_line_data, .o_tx_link_clock, .i_tx_link_data, .o_rx_link_clock, .o_rx_link_data,
    .o_multiframe_align_irq, .o_spare_change_irq);
  e1nb_link_ctrl ctrl_u (.i_link_clock(o_tx_link_clock), .o_link_data(i_tx_link_data));
  initial forever #2.5 i_clk = ~i_clk;
  // ==========================================
  // helpers
  function automatic logic rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[0];
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_cpu_cs = 1;
    i_cpu_wr = wr;
    i_cpu_rd = !wr;
    i_cpu_addr = a;
    i_cpu_wdata = d;
    @(posedge i_clk);
    #1;
    i_cpu_cs = 0;
    i_cpu_wr = 0;
    i_cpu_rd = 0;
  endtask
  // page write first, then the register access
  task automatic cpu_io(input logic [7:0] pg, input logic [3:0] off, input logic wr, input logic [7:0] d);
    bus(1'b1, 5'h00, pg);
    bus(wr, {1'b1, off}, d);
    if (!wr) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  // ==========================================
  // transmit backplane and line model
  task automatic tx_run(input int nf);
    int fi, s;
    logic e, odd;
    for (int f = 1; f <= nf; f++) begin
      fi = f % 16;
      odd = fi[0];
      if (fi == 0) shadow = txbuf;
      for (int k = 1; k <= 16; k++) begin
        repeat (49) @(posedge i_clk);
        #1;
        i_tx_bit_clock = 0;
        i_tx_frame_pulse = (k == 1);
        i_backplane_data_in = rnd();
        if (k == 1) {i_tx_crc_bit, i_tx_remote_alarm, i_tx_remote_crc_err} = {rnd(), rnd(), rnd(), rnd()};
        repeat (49) @(posedge i_clk);
        #1;
        i_tx_bit_clock = 1;
        repeat (10) @(posedge i_clk);
        #1;
        s = 8 - k;
        if (k > 8) e = i_backplane_data_in;
        else if (!odd) e = (k == 1) ? i_tx_crc_bit : FAS_WORD[8 - k];
        else if (k == 1) e = (fi <= 11) ? MFAS_WORD[5 - (fi - 1) / 2] : i_tx_remote_crc_err[fi == 13];
        else if (k < 4) e = (k == 2) ? 1'b1 : i_tx_remote_alarm;
        else if (sel[s]) begin
          e = (q.size() > 0) ? q.pop_front() : 1'b1;
          q.push_back(i_tx_link_data);
        end else if (tsel[s]) e = i_backplane_data_in;
        else e = shadow[k - 4][7 - (fi - 1) / 2];
        check("tx line bit", o_tx_line_data, e);
        check("tx link clock", o_tx_link_clock, odd && k >= 4 && k <= 8 && sel[s]);
      end
    end
  endtask
  // ==========================================
  // receive line model
  task automatic rx_run(input int nf);
    int fi;
    logic odd;
    for (int f = 0; f < nf; f++) begin
      fi = f % 16;
      odd = fi[0];
      for (int k = 1; k <= 16; k++) begin
        repeat (50) @(posedge i_clk);
        #1;
        i_rx_line_clock = 0;
        i_rx_frame_pulse = (k == 1);
        i_rx_multiframe_pulse = (k == 1 && fi == 0);
        i_rx_line_data = rnd();
        repeat (50) @(posedge i_clk);
        #1;
        i_rx_line_clock = 1;
        if (k == 1 && fi == 0) rxexp = rxacc;
        if (odd && k >= 4 && k <= 8) rxacc[k - 4][7 - (fi - 1) / 2] = i_rx_line_data;
        // sa5 bit change against its previous value, idle ones after reset
        if (odd && k == 5) begin
          chg5 = chg5 || i_rx_line_data != prev5;
          prev5 = i_rx_line_data;
        end
        repeat (10) @(posedge i_clk);
        #1;
        check("rx link clock", o_rx_link_clock, odd && k >= 4 && k <= 8 && sel[8 - k]);
        check("rx link data", o_rx_link_data, i_rx_line_data);
      end
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (80000) @(posedge i_clk);
    check("run time", 1, 0);
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1;
    i_sys_rst = 0;
    repeat (2) @(posedge i_clk);
    cpu_io(8'h01, 4'h0, 0, 0);
    check("link select", o_cpu_rdata, 8'h00);
    cpu_io(8'h01, 4'h7, 0, 0);
    check("transparent select", o_cpu_rdata, 8'h00);
    cpu_io(8'h01, 4'hD, 0, 0);
    check("irq mask", o_cpu_rdata, 8'h03);
    cpu_io(8'h05, 4'h3, 0, 0);
    check("unmapped", o_cpu_rdata, 8'h00);
    for (int i = 0; i < 5; i++) begin
      cpu_io(8'h0E, i[3:0], 0, 0);
      check("rx buffer reset", o_cpu_rdata, NBB_RST);
      txbuf[i] = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      shadow[i] = NBB_RST;
      cpu_io(8'h0D, i[3:0], 0, 0);
      check("tx buffer reset", o_cpu_rdata, NBB_RST);
      cpu_io(8'h0D, i[3:0], 1, txbuf[i]);
      cpu_io(8'h0D, i[3:0], 0, 0);
      check("tx buffer", o_cpu_rdata, txbuf[i]);
    end
    cpu_io(8'h0E, 4'h0, 1, 8'h00);
    cpu_io(8'h0E, 4'h0, 0, 0);
    check("rx buffer read only", o_cpu_rdata, NBB_RST);
    cpu_io(8'h01, 4'h0, 1, {3'h0, sel});
    cpu_io(8'h01, 4'h7, 1, {3'h0, tsel});
    cpu_io(8'h01, 4'h9, 1, 8'h18);
    cpu_io(8'h01, 4'h9, 0, 0);
    check("change control", o_cpu_rdata, 8'h18);
    cpu_io(8'h01, 4'hD, 1, 8'h00);
    fork
      tx_run(33);
      begin
        rx_run(17);
        check("align irq", o_multiframe_align_irq, 1);
        check("change irq", o_spare_change_irq, chg5 || rxexp[4] != NBB_RST);
        cpu_io(8'h03, 4'h2, 0, 0);
        check("status", o_cpu_rdata, {3'h0, chg5, 2'h0, rxexp[4] != NBB_RST, 1'b1});
        @(posedge i_clk);
        #1;
        check("align irq cleared", o_multiframe_align_irq, 0);
        check("change irq cleared", o_spare_change_irq, 0);
        for (int i = 0; i < 5; i++) begin
          cpu_io(8'h0E, i[3:0], 0, 0);
          check("rx buffer", o_cpu_rdata, rxexp[i]);
        end
      end
    join
    print_verdict();
  end
endmodule
